/* wbt_pkg.sv */
// Purpose: shared constants and types of the wake, bus and timer control registers
// Assumes: 7-bit register addresses, 8-bit data, 16-bit serial control frames
// Notes: cyclic periods are given in milliseconds for the timer outside this block
`default_nettype none
package wbt_pkg;
	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
	localparam logic [6:0] ADDR_WAKE_TERM = 7'h08;
	localparam logic [6:0] ADDR_PAIR_MODE = 7'h0a;
	localparam logic [6:0] ADDR_CYCLIC = 7'h0c;
	// ****************************************
	// reset values and field masks
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_EXT_WAKE = 8'h01;
	localparam logic [7:0] FAILSAFE_EXT_WAKE = 8'h01;
	localparam logic [7:0] EXT_WAKE_MASK = 8'h01;
	localparam logic [7:0] TERM_MASK = 8'h03;
	localparam logic [7:0] CYC_MASK = 8'h07;
	localparam int CH1_LSB = 0;
	localparam int CH2_LSB = 3;
	localparam int SWK_OFS = 2;
	localparam int FLASH1_BIT = 6;
	localparam int FLASH2_BIT = 7;
	// ****************************************
	// mode codes
	// ****************************************
	localparam logic [1:0] LOW_OFF = 2'h0;
	localparam logic [1:0] LOW_WAKE = 2'h1;
	localparam logic [1:0] LOW_RX = 2'h2;
	localparam logic [1:0] LOW_NORMAL = 2'h3;
	localparam logic [1:0] TERM_NONE = 2'h0;
	localparam logic [1:0] TERM_PULL_DOWN = 2'h1;
	localparam logic [1:0] TERM_PULL_UP = 2'h2;
	localparam logic [1:0] TERM_AUTO = 2'h3;
	localparam logic [2:0] PER_RESERVED = 3'h7;
	localparam logic [11:0] PER_MS_0 = 12'd10;
	localparam logic [11:0] PER_MS_1 = 12'd20;
	localparam logic [11:0] PER_MS_2 = 12'd50;
	localparam logic [11:0] PER_MS_3 = 12'd100;
	localparam logic [11:0] PER_MS_4 = 12'd200;
	localparam logic [11:0] PER_MS_5 = 12'd1000;
	localparam logic [11:0] PER_MS_6 = 12'd2000;
	// ****************************************
	// serial frame layout
	// ****************************************
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HDR_BITS = 5'h08;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} wbt_frame_t;
	typedef enum logic [1:0] {XCVR_OFF, XCVR_WAKE, XCVR_RX_ONLY, XCVR_NORMAL} wbt_xcvr_mode_t;
	typedef struct packed {
		wbt_xcvr_mode_t mode;
		logic swk;
		logic flash;
	} wbt_chan_t;
	typedef struct packed {
		logic sleep;
		logic stop;
		logic failsafe;
		logic restart;
		logic soft_reset;
	} wbt_event_t;
	typedef enum logic [1:0] {TERM_SEL_NONE, TERM_SEL_DOWN, TERM_SEL_UP, TERM_SEL_AUTO} wbt_term_t;
endpackage
`default_nettype wire

/* wbt_spi_frame.sv */
// Purpose: serial control port slave, 16-bit frames, mode 0, msb first
// Assumes: serial clock well below a tenth of ref_clk
// Notes: read byte is shifted out during the second half of the frame
`default_nettype none
module wbt_spi_frame
	import wbt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// pins
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic mosi_pin,
	output logic miso,
	output logic miso_oe,
	// register side
	output logic [6:0] rd_addr,
	input wire logic [7:0] rd_data,
	output wbt_frame_t frame,
	output logic frame_valid
);
	// ****************************************
	// pin synchronisers and filters
	// ****************************************
	logic [2:0] sclk_ff, cs_ff, mosi_ff;
	logic sclk_f, cs_n_f, mosi_f, sclk_q, cs_n_q;
	logic [15:0] shift_reg;
	logic [4:0] cnt_reg;
	logic [7:0] out_reg;
	logic load_reg;
	logic rise, fall, active;
	always_ff @(posedge ref_clk) begin
		sclk_ff <= {sclk_ff[1:0], sclk_pin};
		cs_ff <= {cs_ff[1:0], cs_n_pin};
		mosi_ff <= {mosi_ff[1:0], mosi_pin};
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sclk_f <= 1'b0;
			cs_n_f <= 1'b1;
			mosi_f <= 1'b0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			if (sclk_ff[1] == sclk_ff[2]) sclk_f <= sclk_ff[2];
			if (cs_ff[1] == cs_ff[2]) cs_n_f <= cs_ff[2];
			if (mosi_ff[1] == mosi_ff[2]) mosi_f <= mosi_ff[2];
			sclk_q <= sclk_f;
			cs_n_q <= cs_n_f;
		end
	end
	assign rise = sclk_f & ~sclk_q;
	assign fall = ~sclk_f & sclk_q;
	assign active = ~cs_n_f;
	// ****************************************
	// frame shifting
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst || !active) begin
			cnt_reg <= 5'h00;
		end else if (rise && cnt_reg != CNT_MAX) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift_reg <= 16'h0000;
			rd_addr <= 7'h00;
			load_reg <= 1'b0;
		end else begin
			load_reg <= 1'b0;
			if (active && rise) begin
				shift_reg <= {shift_reg[14:0], mosi_f};
				if (cnt_reg == HDR_BITS - 5'h01) begin
					rd_addr <= {shift_reg[5:0], mosi_f};
					load_reg <= 1'b1;
				end
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst || !active) begin
			out_reg <= 8'h00;
			miso <= 1'b0;
		end else if (load_reg) begin
			miso <= rd_data[7];
			out_reg <= {rd_data[6:0], 1'b0};
		end else if (fall && cnt_reg > HDR_BITS) begin
			miso <= out_reg[7];
			out_reg <= {out_reg[6:0], 1'b0};
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			miso_oe <= 1'b0;
			frame_valid <= 1'b0;
			frame <= '0;
		end else begin
			miso_oe <= active;
			frame_valid <= cs_n_f && !cs_n_q && cnt_reg == FRAME_BITS;
			frame <= shift_reg;
		end
	end
endmodule
`default_nettype wire

/* wbt_regs.sv */
// Purpose: wake termination, transceiver pair mode, cyclic period and external wake registers
// Assumes: mode event pulses come from logic on ref_clk; srst acts as power-on reset
// Notes: hardware events take priority over a host write in the same cycle
//
// Contract
// - fail-safe entry sets external wake to pin only
// - termination field selects none, down, up, auto
// - unused upper bits read as zero
// - mode fields decode off, wake, receive, normal
// - top mode bit selects selective-wake variant
// - flash bits lift rate limit, no slew
// - hardware alters selective-wake select bit only on power-on or soft reset
// - sleep turns error-free normal into wake capable
// - receive-only: sleep to wake, stop keeps
// - wake capable or off stay unchanged
// - fail-safe rewrites bus mode to stay wakeable
// - period codes map 10ms to 2s, 111 reserved
// - power-on and soft reset clear registers but set external wake to 01
// - restart keeps termination, clears cyclic period
// - cyclic wake needs its source enable bit
`default_nettype none
module wbt_regs
	import wbt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// serial control port pins
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic mosi_pin,
	output logic miso,
	output logic miso_oe,
	// mode events and status
	input wire wbt_event_t evt,
	input wire logic [1:0] channel_system_error_flag,
	input wire logic cyclic_wake_source_enable,
	// controls to the analogue and timer blocks
	output wbt_term_t termination_select,
	output wbt_chan_t first_channel_mode,
	output wbt_chan_t second_channel_mode,
	output logic wake_pin_enable,
	output logic [11:0] cyclic_period_ms,
	output logic cyclic_run
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [1:0] lp_low(input logic [1:0] low, input logic err,
		input logic sleep);
		lp_low = low;
		if (sleep && low == LOW_NORMAL && !err) lp_low = LOW_WAKE;
		if (sleep && low == LOW_RX) lp_low = LOW_WAKE;
	endfunction
	function automatic wbt_chan_t decode(input logic [2:0] f, input logic flash);
		wbt_chan_t c;
		c.swk = f[SWK_OFS];
		c.flash = flash;
		case (f[1:0])
			LOW_OFF: c.mode = XCVR_OFF;
			LOW_WAKE: c.mode = XCVR_WAKE;
			LOW_RX: c.mode = XCVR_RX_ONLY;
			default: c.mode = XCVR_NORMAL;
		endcase
		decode = c;
	endfunction
	function automatic logic [11:0] period_ms(input logic [2:0] code);
		case (code)
			3'h0: period_ms = PER_MS_0;
			3'h1: period_ms = PER_MS_1;
			3'h2: period_ms = PER_MS_2;
			3'h3: period_ms = PER_MS_3;
			3'h4: period_ms = PER_MS_4;
			3'h5: period_ms = PER_MS_5;
			3'h6: period_ms = PER_MS_6;
			default: period_ms = 12'h000;
		endcase
	endfunction
	// ****************************************
	// serial port
	// ****************************************
	wbt_frame_t frame;
	logic frame_valid;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] ext_wake_reg, term_reg, pair_reg, cyc_reg, pair_next;
	logic clr, wr_ext, wr_term, wr_pair, wr_cyc;
	wbt_spi_frame u_spi (
		.ref_clk(ref_clk),
		.srst(srst),
		.sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin),
		.mosi_pin(mosi_pin),
		.miso(miso),
		.miso_oe(miso_oe),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.frame(frame),
		.frame_valid(frame_valid)
	);
	assign clr = srst | evt.soft_reset;
	assign wr_ext = frame_valid && frame.wr && frame.addr == ADDR_EXT_WAKE;
	assign wr_term = frame_valid && frame.wr && frame.addr == ADDR_WAKE_TERM;
	assign wr_pair = frame_valid && frame.wr && frame.addr == ADDR_PAIR_MODE;
	assign wr_cyc = frame_valid && frame.wr && frame.addr == ADDR_CYCLIC;
	always_comb begin
		case (rd_addr)
			ADDR_EXT_WAKE: rd_data = ext_wake_reg & EXT_WAKE_MASK;
			ADDR_WAKE_TERM: rd_data = term_reg & TERM_MASK;
			ADDR_PAIR_MODE: rd_data = pair_reg;
			ADDR_CYCLIC: rd_data = cyc_reg & CYC_MASK;
			default: rd_data = RST_ZERO;
		endcase
	end
	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			ext_wake_reg <= RST_EXT_WAKE;
		end else if (evt.failsafe) begin
			ext_wake_reg <= FAILSAFE_EXT_WAKE;
		end else if (wr_ext) begin
			ext_wake_reg <= frame.data & EXT_WAKE_MASK;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			term_reg <= RST_ZERO;
		end else if (evt.restart) begin
			term_reg <= term_reg & TERM_MASK;
		end else if (wr_term) begin
			term_reg <= frame.data & TERM_MASK;
		end
	end
	always_comb begin
		pair_next = pair_reg;
		if (evt.failsafe) begin
			pair_next[CH1_LSB +: 2] = LOW_WAKE;
			pair_next[CH2_LSB +: 2] = LOW_WAKE;
		end else if (evt.sleep || evt.stop) begin
			pair_next[CH1_LSB +: 2] = lp_low(pair_reg[CH1_LSB +: 2],
				channel_system_error_flag[0], evt.sleep);
			pair_next[CH2_LSB +: 2] = lp_low(pair_reg[CH2_LSB +: 2],
				channel_system_error_flag[1], evt.sleep);
		end else if (wr_pair) begin
			pair_next = frame.data;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			pair_reg <= RST_ZERO;
		end else if (!evt.restart) begin
			pair_reg <= pair_next;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (clr || evt.restart) begin
			cyc_reg <= RST_ZERO;
		end else if (wr_cyc) begin
			cyc_reg <= frame.data & CYC_MASK;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	assign termination_select = wbt_term_t'(term_reg[1:0]);
	assign first_channel_mode = decode(pair_reg[CH1_LSB +: 3], pair_reg[FLASH1_BIT]);
	assign second_channel_mode = decode(pair_reg[CH2_LSB +: 3], pair_reg[FLASH2_BIT]);
	assign wake_pin_enable = ext_wake_reg[0];
	assign cyclic_period_ms = period_ms(cyc_reg[2:0]);
	assign cyclic_run = cyclic_wake_source_enable && cyc_reg[2:0] != PER_RESERVED;
	// ****************************************
	// checks
	// ****************************************
	failsafe_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.failsafe && !evt.soft_reset |=> ext_wake_reg == FAILSAFE_EXT_WAKE)
		else $error("external wake not forced on fail-safe");
	term_upper_a: assert property (@(posedge ref_clk) disable iff (srst)
		rd_addr == ADDR_WAKE_TERM |-> rd_data[7:2] == 6'h00)
		else $error("termination upper bits not zero");
	swk_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		!evt.soft_reset && !wr_pair |=> $stable(pair_reg[CH1_LSB + SWK_OFS])
		&& $stable(pair_reg[CH2_LSB + SWK_OFS]))
		else $error("selective wake bit changed by hardware");
	sleep_normal_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.sleep && !evt.failsafe && !evt.restart && !evt.soft_reset
		&& !channel_system_error_flag[0] && pair_reg[1:0] == LOW_NORMAL
		|=> pair_reg[1:0] == LOW_WAKE && first_channel_mode.mode == XCVR_WAKE)
		else $error("normal channel not set wake capable on sleep");
	stop_rx_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.stop && !evt.sleep && !evt.failsafe && !evt.soft_reset
		&& pair_reg[4:3] == LOW_RX |=> pair_reg[4:3] == LOW_RX)
		else $error("receive only lost on stop");
	lp_off_a: assert property (@(posedge ref_clk) disable iff (srst)
		(evt.sleep || evt.stop) && !evt.failsafe && pair_reg[1:0] == LOW_OFF
		|=> pair_reg[1:0] == LOW_OFF)
		else $error("off channel changed on low power entry");
	soft_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.soft_reset |=> term_reg == RST_ZERO && pair_reg == RST_ZERO && cyc_reg == RST_ZERO)
		else $error("soft reset did not clear registers");
	restart_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.restart && !evt.soft_reset |=> term_reg == $past(term_reg) && cyc_reg == RST_ZERO)
		else $error("restart handling wrong");
	reserved_run_a: assert property (@(posedge ref_clk) disable iff (srst)
		cyc_reg[2:0] == PER_RESERVED || !cyclic_wake_source_enable |-> !cyclic_run)
		else $error("cyclic timing started when not allowed");
	fs_pair_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.failsafe && !evt.restart && !evt.soft_reset |=> pair_reg[CH1_LSB +: 2] == LOW_WAKE
		&& pair_reg[CH2_LSB +: 2] == LOW_WAKE)
		else $error("fail-safe did not make channels wake capable");
	sleep_rx_a: assert property (@(posedge ref_clk) disable iff (srst)
		evt.sleep && !evt.failsafe && !evt.restart && !evt.soft_reset
		&& pair_reg[CH2_LSB +: 2] == LOW_RX |=> pair_reg[CH2_LSB +: 2] == LOW_WAKE)
		else $error("receive only not set wake capable on sleep");
	lp_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
		(evt.sleep || evt.stop) && !evt.failsafe && !evt.restart && !evt.soft_reset
		&& pair_reg[CH2_LSB +: 2] == LOW_WAKE |=> pair_reg[CH2_LSB +: 2] == LOW_WAKE)
		else $error("wake capable channel changed on low power entry");
	cyc_upper_a: assert property (@(posedge ref_clk) disable iff (srst)
		rd_addr == ADDR_CYCLIC |-> rd_data[7:3] == 5'h00)
		else $error("cyclic period upper bits not zero");
	chan_off_a: assert property (@(posedge ref_clk) disable iff (srst)
		pair_reg[CH1_LSB +: 2] == LOW_OFF |-> first_channel_mode.mode == XCVR_OFF)
		else $error("off code not decoded as off");
endmodule
`default_nettype wire

/* wbt_host_model.sv */
// Purpose: host side of the serial control port, 16-bit mode 0 frames, msb first
// Assumes: half period of 8 ref_clk cycles, chip select idle 10 cycles after a frame
// Notes: the read byte is taken just before rising edges 9 to 16
`default_nettype none
module wbt_host_model (
	// clock
	input wire logic ref_clk,
	// pins
	input wire logic miso,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 8;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// ****************************************
	// one whole frame: write flag, address, data
	// ****************************************
	task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		mosi <= tx[15];
		repeat (HALF) @(posedge ref_clk);
		for (int i = 15; i >= 0; i--) begin
			if (i < 8) begin
				rx = {rx[6:0], miso};
			end
			sclk <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			sclk <= 1'b0;
			if (i > 0) begin
				mosi <= tx[i-1];
			end
			repeat (HALF) @(posedge ref_clk);
		end
		cs_n <= 1'b1;
		mosi <= ~tx[0];
		repeat (10) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

/* wbt_regs_tb.sv */
// Purpose: self-checking bench of the wake, bus and timer control registers
// Assumes: host model drives the serial port, events are one-cycle pulses
// Notes: expected values come from the field layout only
`default_nettype none
module wbt_regs_tb
	import wbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic sclk_pin, cs_n_pin, mosi_pin, miso, miso_oe, wake_en, run;
	wbt_event_t evt = '0;
	logic [1:0] err = 2'h0;
	logic cyc_en = 1'b0;
	wbt_term_t term;
	wbt_chan_t ch1, ch2;
	logic [11:0] per_ms;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	wbt_regs i_wbt_regs (.ref_clk(ref_clk), .srst(srst), .sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin), .miso(miso), .miso_oe(miso_oe),
		.evt(evt), .channel_system_error_flag(err), .cyclic_wake_source_enable(cyc_en),
		.termination_select(term), .first_channel_mode(ch1), .second_channel_mode(ch2),
		.wake_pin_enable(wake_en), .cyclic_period_ms(per_ms), .cyclic_run(run));
	wbt_host_model i_wbt_host_model (.ref_clk(ref_clk), .miso(miso), .sclk(sclk_pin),
		.cs_n(cs_n_pin), .mosi(mosi_pin));
	always #25 ref_clk = ~ref_clk;
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic give_verdict();
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 90000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic chk(string name, logic [11:0] exp, logic [11:0] seen);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(logic [6:0] a, logic [7:0] d);
		logic [7:0] r;
		i_wbt_host_model.xfer({1'b1, a, d}, r);
	endtask
	task automatic rchk(string name, logic [6:0] a, logic [7:0] exp);
		logic [7:0] r;
		i_wbt_host_model.xfer({1'b0, a, 8'h00}, r);
		chk(name, 12'(exp), 12'(r));
	endtask
	task automatic pulse(logic [4:0] v);
		@(posedge ref_clk);
		evt <= v;
		@(posedge ref_clk);
		evt <= '0;
		repeat (3) @(posedge ref_clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rchk("ext wake", ADDR_EXT_WAKE, 8'h01);
		rchk("term", ADDR_WAKE_TERM, 8'h00);
		rchk("pair", ADDR_PAIR_MODE, 8'h00);
		rchk("cyclic", ADDR_CYCLIC, 8'h00);
		chk("wake pin", 12'h001, 12'(wake_en));
	endtask
	task automatic t_oe();
		logic [7:0] r;
		chk("oe idle", 12'h000, 12'(miso_oe));
		chk("miso idle", 12'h000, 12'(miso));
		fork
			i_wbt_host_model.xfer({1'b0, ADDR_WAKE_TERM, 8'h00}, r);
			begin
				repeat (20) @(posedge ref_clk);
				chk("oe busy", 12'h001, 12'(miso_oe));
			end
		join
		chk("oe rd", 12'h000, 12'(r));
		chk("oe done", 12'h000, 12'(miso_oe));
	endtask
	task automatic t_term();
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_WAKE_TERM, {6'h3f, 2'(c)});
			chk("term sel", 12'(c), 12'(term));
			rchk("term rd", ADDR_WAKE_TERM, {6'h00, 2'(c)});
		end
	endtask
	task automatic t_period();
		logic [11:0] ms [8] = '{PER_MS_0, PER_MS_1, PER_MS_2, PER_MS_3, PER_MS_4,
			PER_MS_5, PER_MS_6, 12'h000};
		@(posedge ref_clk);
		cyc_en <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_CYCLIC, {5'h1f, 3'(c)});
			chk("period ms", ms[c], per_ms);
			chk("run", 12'(c != 7), 12'(run));
			rchk("cyclic rd", ADDR_CYCLIC, {5'h00, 3'(c)});
		end
		wr(ADDR_CYCLIC, 8'h02);
		chk("run on", 12'h001, 12'(run));
		cyc_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("run off", 12'h000, 12'(run));
	endtask
	task automatic t_decode();
		logic [7:0] d;
		for (int c = 0; c < 8; c++) begin
			d = {c[0], ~c[0], 3'(c), 3'(7 - c)};
			wr(ADDR_PAIR_MODE, d);
			chk("ch1", 12'({d[1:0], d[2], d[6]}), 12'(ch1));
			chk("ch2", 12'({d[4:3], d[5], d[7]}), 12'(ch2));
			rchk("pair rd", ADDR_PAIR_MODE, d);
		end
	endtask
	task automatic t_low_power();
		err <= 2'h0;
		wr(ADDR_PAIR_MODE, 8'h3a);
		pulse(5'h10);
		rchk("sleep", ADDR_PAIR_MODE, 8'h29);
		err <= 2'h1;
		wr(ADDR_PAIR_MODE, 8'h23);
		pulse(5'h10);
		rchk("sleep keep", ADDR_PAIR_MODE, 8'h23);
		err <= 2'h2;
		wr(ADDR_PAIR_MODE, 8'h0b);
		pulse(5'h10);
		rchk("sleep err", ADDR_PAIR_MODE, 8'h09);
		err <= 2'h0;
		wr(ADDR_PAIR_MODE, 8'h32);
		pulse(5'h08);
		rchk("stop", ADDR_PAIR_MODE, 8'h32);
		wr(ADDR_PAIR_MODE, 8'h19);
		pulse(5'h08);
		rchk("stop keep", ADDR_PAIR_MODE, 8'h19);
	endtask
	task automatic t_failsafe();
		wr(ADDR_EXT_WAKE, 8'h00);
		rchk("ext wr", ADDR_EXT_WAKE, 8'h00);
		wr(ADDR_PAIR_MODE, 8'hdf);
		pulse(5'h04);
		rchk("fs ext", ADDR_EXT_WAKE, 8'h01);
		chk("fs pin", 12'h001, 12'(wake_en));
		rchk("fs pair", ADDR_PAIR_MODE, 8'hcd);
	endtask
	task automatic t_restart();
		wr(ADDR_WAKE_TERM, 8'h03);
		wr(ADDR_CYCLIC, 8'h05);
		pulse(5'h02);
		rchk("rs term", ADDR_WAKE_TERM, 8'h03);
		rchk("rs cyc", ADDR_CYCLIC, 8'h00);
		wr(7'h0d, 8'hff);
		rchk("unmapped", 7'h0d, 8'h00);
		wr(ADDR_EXT_WAKE, 8'h00);
		wr(ADDR_CYCLIC, 8'h04);
		pulse(5'h01);
		t_reset();
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (6) @(posedge ref_clk);
		t_reset();
		t_oe();
		t_term();
		t_period();
		t_decode();
		t_low_power();
		t_failsafe();
		t_restart();
		give_verdict();
	end
endmodule
`default_nettype wire
